// ===== rtl/afs_pkg.sv
// Constants, types and parameter map of the streaming output and sample-clock block.
// Assumes one 50 MHz system clock; all rates are in hertz.
package afs_pkg;
   // Parameter numbers on the register port
   localparam logic [15:0] ADDR_SAMPLE_RATE = 16'h4e20;
   localparam logic [15:0] ADDR_CLOCK_OUT = 16'h4e8e;
   localparam logic [15:0] ADDR_BUF_DONE = 16'hea92;
   localparam logic [15:0] ADDR_COMMAND = 16'hf000;
   localparam logic [15:0] ADDR_CHAN_EN = 16'hf001;
   localparam logic [15:0] ADDR_CLOCK_MODE = 16'hf002;
   localparam logic [15:0] ADDR_STREAM_MODE = 16'hf003;
   localparam logic [15:0] ADDR_EXT_DIV = 16'hf004;
   localparam logic [15:0] ADDR_STATUS = 16'hf005;

   // Command values
   localparam logic [31:0] CMD_START_WAIT = 32'h0000000c;
   localparam logic [31:0] CMD_WAIT_NEXT = 32'h0000000d;
   localparam logic [31:0] CMD_STOP = 32'h00000014;

   // Rates in Hz
   localparam logic [31:0] SYS_CLK_HZ = 32'h02faf080;
   localparam logic [31:0] PLL_REF_HZ = 32'h02625a00;
   localparam logic [31:0] RATE_MIN_MULTI = 32'h000003e8;
   localparam logic [31:0] RATE_MIN_SINGLE = 32'h001e8480;
   localparam logic [31:0] RATE_MAX_FULL = 32'h07735940;
   localparam logic [31:0] RATE_MAX_STREAM4 = 32'h03b9aca0;
   localparam logic [31:0] EXT_REF_MIN_HZ = 32'h000f4240;
   localparam logic [31:0] EXT_REF_MAX_HZ = 32'h07735940;

   // Quartz rates: 125 MHz divided by 1,2,4,8,10,16,20,40,50,80,100,200,400,500,800,1000,2000
   localparam int QZ_COUNT = 17;
   localparam logic [0:16][31:0] QZ_RATE = '{
      32'h07735940, 32'h03b9aca0, 32'h01dcd650, 32'h00ee6b28, 32'h00bebc20, 32'h00773594,
      32'h005f5e10, 32'h002faf08, 32'h002625a0, 32'h0017d784, 32'h001312d0, 32'h00098968,
      32'h0004c4b4, 32'h0003d090, 32'h0002625a, 32'h0001e848, 32'h0000f424};

   // Values after reset
   localparam logic [31:0] RATE_RESET = 32'h00989680;
   localparam logic [3:0] CHAN_EN_RESET = 4'h1;
   localparam logic [15:0] EXT_DIV_RESET = 16'h0001;

   typedef enum logic [2:0] {
      CLK_PLL_INT = 3'h0,
      CLK_QUARTZ = 3'h1,
      CLK_EXT_REF = 3'h2,
      CLK_EXT_DIRECT = 3'h3,
      CLK_EXT_DIV = 3'h4
   } afs_clk_mode_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CALC = 3'b010,
      ST_BLOCK = 3'b100
   } afs_state_type;
endpackage

// ===== rtl/afs_rate_nco.sv
// Phase accumulator that turns a rate in Hz into one-cycle sample ticks.
// Assumes the rate is stable while enabled; rates at or above the system clock tick every cycle.
`timescale 1ns/1ns
module afs_rate_nco #(
   parameter int W = 32
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic [W-1:0] rateHz,
   output logic tick
);
   typedef struct packed {
      logic [W-1:0] acc;
      logic tick;
   } afs_nco_type;

   afs_nco_type st_r, st_nxt;
   logic [W:0] sum;

   always_comb begin
      st_nxt = st_r;
      sum = {1'b0, st_r.acc} + {1'b0, rateHz};
      st_nxt.tick = 1'b0;
      if (!enable) begin
         st_nxt.acc = '0;
      end else if (sum >= {1'b0, afs_pkg::SYS_CLK_HZ}) begin
         st_nxt.tick = 1'b1;
         // Subtracting keeps the long-term average exact
         st_nxt.acc = W'(sum - {1'b0, afs_pkg::SYS_CLK_HZ});
         if (rateHz >= afs_pkg::SYS_CLK_HZ) st_nxt.acc = '0;
      end else begin
         st_nxt.acc = sum[W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign tick = st_r.tick;
endmodule // afs_rate_nco

// ===== rtl/afs_interleave.sv
// Sorts the streamed byte sequence into per-channel samples and presents a frame per tick.
// Assumes chanEn only changes while the stream is stopped.
`timescale 1ns/1ns
module afs_interleave #(
   parameter int DW = 8,
   parameter int CH = 4
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [CH-1:0] chanEn,
   input wire logic allow,
   input wire logic [DW-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   input wire logic tick,
   output logic [CH-1:0][DW-1:0] chanData,
   output logic frameStrobe
);
   typedef struct packed {
      logic [CH-1:0][DW-1:0] frame;
      logic [CH-1:0][DW-1:0] outData;
      logic [2:0] fill;
      logic ready;
      logic strobe;
   } afs_ilv_type;

   afs_ilv_type st_r, st_nxt;
   logic [2:0] nch;
   logic [1:0] slot;

   always_comb begin
      st_nxt = st_r;
      st_nxt.strobe = 1'b0;
      nch = 3'h0;
      unique case (chanEn)
         4'b0001: nch = 3'h1;
         4'b0011, 4'b0101: nch = 3'h2;
         4'b1111: nch = 3'h4;
         default: nch = 3'h0; // Other sets take no data at all
      endcase
      slot = 2'h0;
      if (nch == 3'h2 && st_r.fill[0]) slot = chanEn[1] ? 2'h1 : 2'h2;
      if (nch == 3'h4) begin
         unique case (st_r.fill[1:0])
            2'h0: slot = 2'h0;
            2'h1: slot = 2'h2;
            2'h2: slot = 2'h1;
            2'h3: slot = 2'h3;
         endcase
      end
      if (nch != 3'h0 && st_r.fill == nch && tick) begin
         st_nxt.outData = st_r.frame; // Bytes pass unchanged
         st_nxt.fill = 3'h0;
         st_nxt.strobe = 1'b1;
      end else if (inValid && st_r.ready) begin
         st_nxt.frame[slot] = inData;
         st_nxt.fill = st_r.fill + 3'h1;
      end
      if (nch == 3'h0) st_nxt.fill = 3'h0;
      st_nxt.ready = allow && nch != 3'h0 && st_nxt.fill < nch;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign inReady = st_r.ready;
   assign chanData = st_r.outData;
   assign frameStrobe = st_r.strobe;

   order_four_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (chanEn == 4'b1111 && st_r.fill == 3'h1 && inValid && st_r.ready && !(tick && st_r.fill == nch))
      |=> st_r.frame[2] == $past(inData))
      else $error("Second byte of a four-channel frame did not go to channel 2");
   bad_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !(chanEn inside {4'b0001, 4'b0011, 4'b0101, 4'b1111}) |=> !st_r.ready)
      else $error("Illegal channel set accepted data");
endmodule // afs_interleave

// ===== rtl/afs_stream_clock.sv
// Top of the streaming output path and sample-clock selection of the waveform generator.
// Assumes one access at a time on the parameter port; the caller waits for regAck.
`timescale 1ns/1ns

// Summary of operation
// - Start command begins fetching data at once
// - One channel: samples in plain order
// - Two channels alternate lower then higher
// - Four channels ordered 0, 2, 1, 3
// - Sample encoding same as normal mode
// - Default mode: PLL from 40 MHz reference
// - Rate write sets desired internal rate
// - Rate read returns nearest achievable rate
// - Clock output only with internal clocking
// - Minimum 1 kHz with several channels
// - Minimum 2 MHz with one channel; in quartz mode the nearest divider rate, 1.5625 MHz, lies below it
// - Normal mode allows up to 125 MS/s
// - Streaming four channels capped at 62.5 MS/s
// - External reference between 1 and 125 MHz
// - Quartz mode uses permitted divider rates
// - External clock divided for slower rate
// - Direct external clock drives sampling
// - Start and wait block until buffer event
module afs_stream_clock #(
   parameter int NUM_BUF = 64,
   parameter int BUF_LEN = 8192,
   parameter int DW = 8,
   parameter int CH = 4
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic regSel,
   input wire logic regWrite,
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regWdata,
   output logic [31:0] regRdata,
   output logic regAck,
   input wire logic [DW-1:0] fetchData,
   input wire logic fetchValid,
   output logic fetchReady,
   input wire logic extClkIn,
   output logic clkPinOut,
   output logic clkPinOe_n,
   output logic [CH-1:0][DW-1:0] dacData,
   output logic dacStrobe,
   output logic bufferEvent
);
   typedef struct packed {
      afs_pkg::afs_state_type state;
      logic [31:0] rateReq;
      logic [31:0] rateAch;
      logic [31:0] clamped;
      logic [31:0] bestDiff;
      logic [4:0] qzIdx;
      logic clkOutEn;
      logic [2:0] clockMode;
      logic [CH-1:0] chanEn;
      logic streamMode;
      logic [15:0] extDiv;
      logic [15:0] extCnt;
      logic extPrev;
      logic running;
      logic [8:0] readyCnt;
      logic [15:0] byteCnt;
      logic [7:0] bufIdx;
      logic evtPend;
      logic evtPulse;
      logic ack;
      logic [31:0] rdata;
      logic pinOut;
      logic pinOe_n;
      logic tick;
   } afs_top_type;

   afs_top_type st_r, st_nxt;
   logic ncoTick;
   logic ilvReady;
   logic allow;
   logic take;
   logic [31:0] rMin;
   logic [31:0] rMax;
   logic [31:0] diff;
   logic [2:0] nch;
   logic internalClk;
   logic extRise;
   logic bufEnd;
   logic [afs_pkg::QZ_COUNT-1:0] qzHit;

   for (genvar g = 0; g < afs_pkg::QZ_COUNT; g++) begin : g_qz
      assign qzHit[g] = (st_r.rateAch == afs_pkg::QZ_RATE[g]);
   end

   afs_rate_nco #(.W(32)) u_nco (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .enable(st_r.running),
      .rateHz(st_r.rateAch),
      .tick(ncoTick)
   );

   afs_interleave #(.DW(DW), .CH(CH)) u_ilv (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .chanEn(st_r.chanEn),
      .allow(allow),
      .inData(fetchData),
      .inValid(fetchValid),
      .inReady(ilvReady),
      .tick(st_r.tick),
      .chanData(dacData),
      .frameStrobe(dacStrobe)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.evtPulse = 1'b0;
      st_nxt.tick = 1'b0;
      take = regSel && (st_r.state == afs_pkg::ST_IDLE) && !st_r.ack;
      nch = 3'h0;
      unique case (st_r.chanEn)
         4'b0001: nch = 3'h1;
         4'b0011, 4'b0101: nch = 3'h2;
         4'b1111: nch = 3'h4;
         default: nch = 3'h0;
      endcase
      // Limits for the active channel count and mode
      rMin = (nch == 3'h1) ? afs_pkg::RATE_MIN_SINGLE : afs_pkg::RATE_MIN_MULTI;
      rMax = afs_pkg::RATE_MAX_FULL;
      if (st_r.streamMode && nch == 3'h4) rMax = afs_pkg::RATE_MAX_STREAM4;
      diff = (st_r.clamped > afs_pkg::QZ_RATE[st_r.qzIdx]) ? st_r.clamped - afs_pkg::QZ_RATE[st_r.qzIdx]
         : afs_pkg::QZ_RATE[st_r.qzIdx] - st_r.clamped;
      internalClk = st_r.clockMode inside {afs_pkg::CLK_PLL_INT, afs_pkg::CLK_QUARTZ, afs_pkg::CLK_EXT_REF};

      // Sample tick source per clock mode
      extRise = extClkIn && !st_r.extPrev;
      st_nxt.extPrev = extClkIn;
      if (internalClk) begin
         st_nxt.tick = ncoTick;
      end else if (st_r.clockMode == afs_pkg::CLK_EXT_DIRECT) begin
         st_nxt.tick = extRise && st_r.running;
      end else if (extRise && st_r.running) begin
         if (st_r.extCnt + 16'h1 >= st_r.extDiv) begin
            st_nxt.extCnt = 16'h0;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.extCnt = st_r.extCnt + 16'h1;
         end
      end
      // Clock connector drives only with an internal clock
      st_nxt.pinOe_n = !(st_r.clkOutEn && internalClk);
      st_nxt.pinOut = st_nxt.tick && !st_nxt.pinOe_n;

      // Byte accounting per buffer
      bufEnd = 1'b0;
      if (fetchValid && ilvReady) begin
         if (st_r.byteCnt == 16'(BUF_LEN - 1)) begin
            bufEnd = 1'b1;
            st_nxt.byteCnt = 16'h0;
            st_nxt.bufIdx = (st_r.bufIdx == 8'(NUM_BUF - 1)) ? 8'h0 : st_r.bufIdx + 8'h1;
            st_nxt.readyCnt = st_r.readyCnt - 9'h1;
            st_nxt.evtPulse = 1'b1;
         end else begin
            st_nxt.byteCnt = st_r.byteCnt + 16'h1;
         end
      end

      unique case (st_r.state)
         afs_pkg::ST_IDLE: begin
            if (take) begin
               st_nxt.ack = 1'b1;
               st_nxt.rdata = 32'h0;
               if (regWrite) begin
                  unique case (regAddr)
                     afs_pkg::ADDR_SAMPLE_RATE: begin
                        st_nxt.rateReq = regWdata;
                        st_nxt.state = afs_pkg::ST_CALC;
                        st_nxt.ack = 1'b0;
                     end
                     afs_pkg::ADDR_CLOCK_OUT: st_nxt.clkOutEn = regWdata[0];
                     afs_pkg::ADDR_CHAN_EN: st_nxt.chanEn = regWdata[CH-1:0];
                     afs_pkg::ADDR_CLOCK_MODE: st_nxt.clockMode = regWdata[2:0];
                     afs_pkg::ADDR_STREAM_MODE: st_nxt.streamMode = regWdata[0];
                     afs_pkg::ADDR_EXT_DIV: st_nxt.extDiv = (regWdata[15:0] == 16'h0) ? 16'h1 : regWdata[15:0];
                     afs_pkg::ADDR_BUF_DONE: begin
                        // Each handed-back index frees one buffer
                        if (st_nxt.readyCnt < 9'(NUM_BUF)) st_nxt.readyCnt = st_nxt.readyCnt + 9'h1;
                     end
                     afs_pkg::ADDR_COMMAND: begin
                        if (regWdata == afs_pkg::CMD_START_WAIT) begin
                           st_nxt.running = 1'b1;
                           st_nxt.readyCnt = 9'(NUM_BUF);
                           st_nxt.byteCnt = 16'h0;
                           st_nxt.bufIdx = 8'h0;
                           st_nxt.evtPend = 1'b0;
                           st_nxt.extCnt = 16'h0;
                           st_nxt.state = afs_pkg::ST_BLOCK;
                           st_nxt.ack = 1'b0;
                        end else if (regWdata == afs_pkg::CMD_WAIT_NEXT && st_r.running) begin
                           st_nxt.state = afs_pkg::ST_BLOCK;
                           st_nxt.ack = 1'b0;
                        end else if (regWdata == afs_pkg::CMD_STOP) begin
                           st_nxt.running = 1'b0;
                        end
                     end
                     default: st_nxt.ack = 1'b1;
                  endcase
                  // Limits depend on channels and mode, so recompute
                  if (regAddr inside {afs_pkg::ADDR_CHAN_EN, afs_pkg::ADDR_CLOCK_MODE, afs_pkg::ADDR_STREAM_MODE}) begin
                     st_nxt.state = afs_pkg::ST_CALC;
                     st_nxt.ack = 1'b0;
                  end
               end else begin
                  unique case (regAddr)
                     afs_pkg::ADDR_SAMPLE_RATE: st_nxt.rdata = st_r.rateAch;
                     afs_pkg::ADDR_CLOCK_OUT: st_nxt.rdata = {31'h0, st_r.clkOutEn};
                     afs_pkg::ADDR_CHAN_EN: st_nxt.rdata = 32'(st_r.chanEn);
                     afs_pkg::ADDR_CLOCK_MODE: st_nxt.rdata = {29'h0, st_r.clockMode};
                     afs_pkg::ADDR_STREAM_MODE: st_nxt.rdata = {31'h0, st_r.streamMode};
                     afs_pkg::ADDR_EXT_DIV: st_nxt.rdata = {16'h0, st_r.extDiv};
                     afs_pkg::ADDR_STATUS: st_nxt.rdata = {7'h0, st_r.running, st_r.readyCnt, st_r.bufIdx};
                     default: st_nxt.rdata = 32'h0;
                  endcase
               end
            end
            // Limits follow the values being written, else a channel change clamps stale
            unique case (st_nxt.chanEn)
               4'b0001: nch = 3'h1;
               4'b0011, 4'b0101: nch = 3'h2;
               4'b1111: nch = 3'h4;
               default: nch = 3'h0;
            endcase
            rMin = (nch == 3'h1) ? afs_pkg::RATE_MIN_SINGLE : afs_pkg::RATE_MIN_MULTI;
            rMax = (st_nxt.streamMode && nch == 3'h4) ? afs_pkg::RATE_MAX_STREAM4 : afs_pkg::RATE_MAX_FULL;
            // Clamp happens on the cycle CALC is entered
            st_nxt.clamped = (st_nxt.rateReq < rMin) ? rMin : (st_nxt.rateReq > rMax) ? rMax : st_nxt.rateReq;
            st_nxt.qzIdx = 5'h0;
            st_nxt.bestDiff = 32'hffffffff;
         end
         afs_pkg::ST_CALC: begin
            if (st_r.clockMode == 3'(afs_pkg::CLK_QUARTZ)) begin
               // Serial search over the divider table costs 17 cycles, saves 16 comparators
               if (diff < st_r.bestDiff) begin
                  st_nxt.bestDiff = diff;
                  st_nxt.rateAch = afs_pkg::QZ_RATE[st_r.qzIdx];
               end
               if (st_r.qzIdx == 5'(afs_pkg::QZ_COUNT - 1)) begin
                  st_nxt.state = afs_pkg::ST_IDLE;
                  st_nxt.ack = 1'b1;
               end else begin
                  st_nxt.qzIdx = st_r.qzIdx + 5'h1;
               end
            end else begin
               // PLL resolution taken as 1 Hz
               st_nxt.rateAch = st_r.clamped;
               st_nxt.state = afs_pkg::ST_IDLE;
               st_nxt.ack = 1'b1;
            end
         end
         afs_pkg::ST_BLOCK: begin
            if (st_r.evtPend || bufEnd || !st_r.running) begin
               st_nxt.evtPend = 1'b0;
               st_nxt.state = afs_pkg::ST_IDLE;
               st_nxt.ack = 1'b1;
            end
         end
      endcase
      // An event arriving outside a wait is kept for the next wait
      if (bufEnd && st_r.state != afs_pkg::ST_BLOCK) st_nxt.evtPend = 1'b1;
      allow = st_nxt.running && st_nxt.readyCnt != 9'h0;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.state <= afs_pkg::ST_IDLE;
         st_r.rateReq <= afs_pkg::RATE_RESET;
         st_r.rateAch <= afs_pkg::RATE_RESET;
         st_r.chanEn <= afs_pkg::CHAN_EN_RESET;
         st_r.extDiv <= afs_pkg::EXT_DIV_RESET;
         st_r.pinOe_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdata = st_r.rdata;
   assign regAck = st_r.ack;
   assign fetchReady = ilvReady;
   assign clkPinOut = st_r.pinOut;
   assign clkPinOe_n = st_r.pinOe_n;
   assign bufferEvent = st_r.evtPulse;

   start_fetch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (take && regWrite && regAddr == afs_pkg::ADDR_COMMAND && regWdata == afs_pkg::CMD_START_WAIT
       && st_r.chanEn == afs_pkg::CHAN_EN_RESET) |=> fetchReady)
      else $error("Start did not open the fetch path");
   start_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st_r.state == afs_pkg::ST_BLOCK && !st_r.evtPend && !bufEnd && st_r.running) |=> !regAck)
      else $error("Blocking command answered without a buffer event");
   rate_max_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st_r.state == afs_pkg::ST_IDLE && st_r.streamMode && st_r.chanEn == 4'b1111 && regAck)
      |-> st_r.rateAch <= afs_pkg::RATE_MAX_STREAM4)
      else $error("Streaming four-channel rate above 62.5 MS/s");
   rate_min_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ($rose(regAck) && $past(st_r.state) == afs_pkg::ST_CALC && st_r.chanEn == 4'b0001)
      |-> st_r.rateAch >= afs_pkg::RATE_MIN_SINGLE)
      else $error("Single-channel rate below 2 MHz");
   rate_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (take && !regWrite && regAddr == afs_pkg::ADDR_SAMPLE_RATE) |=> regAck && regRdata == $past(st_r.rateAch))
      else $error("Rate read did not return the achieved rate");
   clk_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st_r.clockMode == 3'(afs_pkg::CLK_EXT_DIRECT)) |=> clkPinOe_n)
      else $error("Clock connector driven under external clocking");
   ext_div_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st_r.clockMode == 3'(afs_pkg::CLK_EXT_DIV) && st_r.tick) |-> $past(st_r.extCnt) + 16'h1 >= st_r.extDiv)
      else $error("Divided external tick came early");
   quartz_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ($rose(regAck) && $past(st_r.state) == afs_pkg::ST_CALC && st_r.clockMode == 3'(afs_pkg::CLK_QUARTZ))
      |-> qzHit != '0)
      else $error("Quartz rate not in divider table");
endmodule // afs_stream_clock

// ===== verification/afs_host_model.sv
// Host-side byte source for the streaming path: counts 1, 2, 3 ... one byte per accepted transfer.
// Assumes all host buffers were filled before start, so a byte is always on offer.
`timescale 1ns/1ns
module afs_host_model (
   ref_clk,
   reset_n,
   fetchReady,
   fetchData,
   fetchValid
);
   input wire logic ref_clk;
   input wire logic reset_n;
   input wire logic fetchReady;
   output logic [7:0] fetchData;
   output logic fetchValid;

   logic [7:0] count_r;

   // Buffers loaded before start, so data is always valid
   assign fetchValid = 1'b1;
   assign fetchData = count_r;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_r <= 8'h01;
      end else if (fetchReady) begin
         count_r <= count_r + 8'h01;
      end
   end
endmodule // afs_host_model

// ===== verification/tb_afs_stream_clock.sv
// Self-checking bench for the streaming output and sample-clock block.
// Assumes small buffer sizes (8 bytes, 4 buffers) so a stream pass stays short.
`timescale 1ns/1ns
module tb_afs_stream_clock;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic regSel = 1'b0;
   logic regWrite = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [31:0] regWdata = 32'h00000000;
   logic [31:0] regRdata;
   logic regAck;
   logic [7:0] fetchData;
   logic fetchValid;
   logic fetchReady;
   logic extClkIn = 1'b0;
   logic clkPinOut;
   logic clkPinOe_n;
   logic [3:0][7:0] dacData;
   logic dacStrobe;
   logic bufferEvent;
   int errorCnt = 0;
   int samplesChecked = 0;
   logic [31:0] frames[$];
   logic [31:0] rd;
   int events = 0;
   int pinPulses = 0;

   always #10 ref_clk = ~ref_clk;
   always #70 extClkIn = ~extClkIn;

   afs_stream_clock #(.NUM_BUF(4), .BUF_LEN(8), .DW(8), .CH(4)) uut (
      .ref_clk(ref_clk), .reset_n(reset_n), .regSel(regSel), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck), .fetchData(fetchData),
      .fetchValid(fetchValid), .fetchReady(fetchReady), .extClkIn(extClkIn), .clkPinOut(clkPinOut),
      .clkPinOe_n(clkPinOe_n), .dacData(dacData), .dacStrobe(dacStrobe), .bufferEvent(bufferEvent));

   afs_host_model host (.ref_clk(ref_clk), .reset_n(reset_n), .fetchReady(fetchReady),
      .fetchData(fetchData), .fetchValid(fetchValid));

   always @(posedge ref_clk) begin
      if (dacStrobe === 1'b1) begin
         frames.push_back(dacData);
      end
      if (bufferEvent === 1'b1) events++;
      if (clkPinOut === 1'b1) pinPulses++;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
         errorCnt++;
      end
   endtask

   // Held until acknowledged; released in the acknowledge cycle
   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      #1;
      regSel = 1'b1;
      regWrite = w;
      regAddr = a;
      regWdata = d;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (regAck !== 1'b1 && n < 3000);
      q = regRdata;
      if (n >= 3000) begin
         $display("unexpected acknowledge: expected 1 seen none");
         errorCnt++;
      end
      regSel = 1'b0;
   endtask

   task automatic testReset();
      acc(1'b0, afs_pkg::ADDR_SAMPLE_RATE, 32'h0, rd);
      chk("reset rate", rd, afs_pkg::RATE_RESET);
      acc(1'b0, afs_pkg::ADDR_CLOCK_OUT, 32'h0, rd);
      chk("reset clock out", rd, 32'h00000000);
      acc(1'b0, 16'h1234, 32'h0, rd);
      chk("unmapped read", rd, 32'h00000000);
   endtask

   task automatic testClamp();
      acc(1'b1, afs_pkg::ADDR_SAMPLE_RATE, 32'h000003e8, rd);
      acc(1'b0, afs_pkg::ADDR_SAMPLE_RATE, 32'h0, rd);
      chk("single min", rd, afs_pkg::RATE_MIN_SINGLE);
      acc(1'b1, afs_pkg::ADDR_CHAN_EN, 32'h00000003, rd);
      acc(1'b1, afs_pkg::ADDR_SAMPLE_RATE, 32'h000003e8, rd);
      acc(1'b0, afs_pkg::ADDR_SAMPLE_RATE, 32'h0, rd);
      chk("multi min", rd, afs_pkg::RATE_MIN_MULTI);
      acc(1'b1, afs_pkg::ADDR_SAMPLE_RATE, 32'h0bebc200, rd);
      acc(1'b0, afs_pkg::ADDR_SAMPLE_RATE, 32'h0, rd);
      chk("normal max", rd, afs_pkg::RATE_MAX_FULL);
      acc(1'b1, afs_pkg::ADDR_STREAM_MODE, 32'h00000001, rd);
      acc(1'b1, afs_pkg::ADDR_CHAN_EN, 32'h0000000f, rd);
      acc(1'b1, afs_pkg::ADDR_SAMPLE_RATE, 32'h05f5e100, rd);
      acc(1'b0, afs_pkg::ADDR_SAMPLE_RATE, 32'h0, rd);
      chk("stream four max", rd, afs_pkg::RATE_MAX_STREAM4);
      acc(1'b1, afs_pkg::ADDR_SAMPLE_RATE, 32'h000f4241, rd);
      acc(1'b0, afs_pkg::ADDR_SAMPLE_RATE, 32'h0, rd);
      chk("in range rate", rd, 32'h000f4241);
   endtask

   task automatic testQuartz();
      acc(1'b1, afs_pkg::ADDR_CLOCK_MODE, 32'h00000001, rd);
      acc(1'b1, afs_pkg::ADDR_SAMPLE_RATE, 32'h01c9c380, rd);
      acc(1'b0, afs_pkg::ADDR_SAMPLE_RATE, 32'h0, rd);
      chk("quartz nearest", rd, afs_pkg::QZ_RATE[2]);
      acc(1'b1, afs_pkg::ADDR_CLOCK_MODE, 32'h00000000, rd);
   endtask

   // Four channels: bytes arrive ch0, ch2, ch1, ch3 per sample index
   task automatic testStream();
      acc(1'b1, afs_pkg::ADDR_SAMPLE_RATE, 32'h000f4240, rd);
      acc(1'b1, afs_pkg::ADDR_CLOCK_OUT, 32'h00000001, rd);
      acc(1'b0, afs_pkg::ADDR_CLOCK_OUT, 32'h0, rd);
      chk("clock out enable", rd, 32'h00000001);
      acc(1'b1, afs_pkg::ADDR_COMMAND, afs_pkg::CMD_START_WAIT, rd);
      chk("clock pin driven", {31'h0, clkPinOe_n}, 32'h0);
      acc(1'b1, afs_pkg::ADDR_BUF_DONE, 32'h00000000, rd);
      acc(1'b1, afs_pkg::ADDR_COMMAND, afs_pkg::CMD_WAIT_NEXT, rd);
      chk("frames seen", (frames.size() >= 2) ? 32'h1 : 32'h0, 32'h1);
      for (int k = 0; k < 2 && k < frames.size(); k++) begin
         chk("frame", frames[k], {8'(4*k+4), 8'(4*k+2), 8'(4*k+3), 8'(4*k+1)});
      end
      acc(1'b1, afs_pkg::ADDR_CLOCK_MODE, 32'h00000003, rd);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("clock pin released", {31'h0, clkPinOe_n}, 32'h1);
      chk("buffer events", (events >= 2) ? 32'h1 : 32'h0, 32'h1);
      chk("clock pin pulses", (pinPulses > 0) ? 32'h1 : 32'h0, 32'h1);
      acc(1'b1, afs_pkg::ADDR_COMMAND, afs_pkg::CMD_STOP, rd);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      testReset();
      testClamp();
      testQuartz();
      testStream();
      results();
   end

   // Normal run is a few hundred cycles
   initial begin
      #400000;
      errorCnt++;
      results();
   end
endmodule // tb_afs_stream_clock
